/* common/output_clock_regs.svh */
/*
  Register offsets, field positions, reset values and tap indices for the
  output clock frequency select block.
  Assumes an 8-bit register port with 8-bit offsets.
*/
`ifndef OUTPUT_CLOCK_REGS_SVH
`define OUTPUT_CLOCK_REGS_SVH

// ==========================================================================
// Register offsets
`define OFS_LF_SOURCE       8'h35
`define OFS_DIG_STANDARD    8'h38
`define OFS_DIG_SELECT      8'h39
`define OFS_OUT_ONE_TWO     8'h60
`define OFS_OUT_THREE_FOUR  8'h61
`define OFS_OUT_FIVE_SIX    8'h62
`define OFS_OUT_SEVEN_EN    8'h63
`define OFS_AUX_MODE        8'h64
`define OFS_SYS_MODE        8'h65
`define OFS_SYNC_SHAPE      8'h7A

// ==========================================================================
// Reset values
`define RST_REG             8'h00
`define RST_FIELD3          3'h0
`define RST_FIELD4          4'h0
`define RST_BIT             1'b0

// ==========================================================================
// Field positions
`define F_LO_NIB            3:0
`define F_HI_NIB            7:4
`define F_MODE              2:0
`define F_AUX_FROM_SYS_SEL  5:4
`define B_AUX_FROM_SYS_EN   6
`define B_CC_LINE_SOURCE    4
`define B_AUX_FB_DIGITAL    6
`define B_DIG_ONE_STD       5
`define B_DIG_TWO_STD       6
`define F_DIG_ONE_SEL       5:4
`define F_DIG_TWO_SEL       7:6
`define B_CC_ENABLE         4
`define B_LINE_ENABLE       5
`define B_FS_DISABLE        6
`define B_MFS_DISABLE       7
`define B_LF_FROM_AUX       7
`define F_SHAPE_8K          3:2
`define F_SHAPE_2K          1:0
`define B_SHAPE_PULSE       0
`define B_SHAPE_INVERT      1
`define B_RESERVED_HI       2
`define F_MODE_UPPER        7:3
`define AUX_FROM_SYS_CODE   2'b10

// ==========================================================================
// Output indices and divider tap positions
`define IDX_OUT_THREE       3'd2
`define IDX_OUT_FOUR        3'd3
`define IDX_OUT_FIVE        3'd4
`define IDX_OUT_SIX         3'd5
`define IDX_OUT_SEVEN       3'd6
`define ST_DIV1             0
`define ST_DIV2             1
`define ST_DIV4             2
`define ST_DIV6             3
`define ST_DIV8             4
`define ST_DIV12            5
`define ST_DIV16            6
`define ST_DIV48            7
`define AT_DIV2             0
`define AT_DIV4             1
`define AT_DIV8             2
`define AT_DIV16            3
`define AT_DIV48            4
`define AT_DIV64            5
`define SH_SYS_8K           0
`define SH_SYS_2K           1
`define SH_LF_8K            2
`define SH_LF_2K            3

`endif

/* common/output_clock_pkg.sv */
/*
  Types for the output clock frequency select block.
  Assumes output_clock_regs.svh supplies the numeric constants.
*/
package output_clock_pkg;

  // ========================================================================
  // Output select codes
  typedef enum logic [3:0] {
    SEL_OFF = 4'h0, SEL_2K = 4'h1, SEL_8K = 4'h2, SEL_DIG_TWO = 4'h3,
    SEL_DIG_ONE = 4'h4, SEL_SYS_48 = 4'h5, SEL_SYS_16 = 4'h6, SEL_SYS_12 = 4'h7,
    SEL_SYS_8 = 4'h8, SEL_SYS_6 = 4'h9, SEL_SYS_4 = 4'hA, SEL_AUX_64 = 4'hB,
    SEL_AUX_48 = 4'hC, SEL_AUX_16 = 4'hD, SEL_AUX_8 = 4'hE, SEL_AUX_4 = 4'hF
  } out_sel_t;

  // ========================================================================
  // System path modes
  typedef enum logic [2:0] {
    SYS_NORMAL_DIGITAL = 3'h0, SYS_NORMAL_ANALOG = 3'h1,
    SYS_TWELVE_E1 = 3'h2, SYS_SIXTEEN_E1 = 3'h3,
    SYS_TWENTYFOUR_DS1 = 3'h4, SYS_SIXTEEN_DS1 = 3'h5
  } sys_mode_t;

  // ========================================================================
  // Effective aux APLL modes: own modes, then modes fed from system path
  typedef enum logic [3:0] {
    AUX_SQUELCHED = 4'h0, AUX_NORMAL = 4'h1, AUX_TWELVE_E1 = 4'h2,
    AUX_SIXTEEN_E1 = 4'h3, AUX_TWENTYFOUR_DS1 = 4'h4, AUX_SIXTEEN_DS1 = 4'h5,
    AUX_E3 = 4'h6, AUX_DS3 = 4'h7, AUX_SYS_TWELVE_E1 = 4'h8,
    AUX_SYS_SIXTEEN_E1 = 4'h9, AUX_SYS_TWENTYFOUR_DS1 = 4'hA,
    AUX_SYS_SIXTEEN_DS1 = 4'hB
  } aux_mode_t;

  // ========================================================================
  // Sync shaping codes: bit 0 pulse, bit 1 invert
  typedef enum logic [1:0] {
    SHAPE_CLOCK = 2'b00, SHAPE_PULSE = 2'b01,
    SHAPE_CLOCK_INV = 2'b10, SHAPE_PULSE_INV = 2'b11
  } shape_t;

endpackage

/* hdl/output_clock_select.sv */
/*
  Output clock frequency select: register file, per-output clock routing,
  composite and line-rate gating, sync output shaping.
  Assumes all divided APLL taps, digital frequencies and low rate clocks
  arrive as levels synchronous to clk; the analog parts sit outside.
*/
`timescale 1ns/1ps
`include "output_clock_regs.svh"

module output_clock_select
  import output_clock_pkg::*;
#(
  parameter int NUM_OUTS = 7
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  input wire logic [7:0] sys_taps,
  input wire logic [5:0] aux_taps,
  input wire logic sys_8k,
  input wire logic sys_2k,
  input wire logic aux_8k,
  input wire logic aux_2k,
  input wire logic digital_freq_one,
  input wire logic digital_freq_two,
  input wire logic sys_composite,
  input wire logic sys_line_rate,
  input wire logic aux_composite,
  input wire logic aux_line_rate,
  output logic [2:0] sys_mode_q,
  output logic [3:0] aux_mode_q,
  output logic aux_feedback_digital_q,
  output logic [2:0] digital_freq_one_code_q,
  output logic [2:0] digital_freq_two_code_q,
  output logic [NUM_OUTS-1:0] clk_out_q,
  output logic composite_clock_out_q,
  output logic line_rate_out_q,
  output logic frame_sync_out_q,
  output logic multiframe_sync_out_q
);

  // ========================================================================
  // Register file
  logic [7:0] lf_source_q;
  logic [7:0] dig_standard_q;
  logic [7:0] dig_select_q;
  logic [7:0] out_one_two_q;
  logic [7:0] out_three_four_q;
  logic [7:0] out_five_six_q;
  logic [7:0] out_seven_en_q;
  logic [7:0] aux_mode_reg_q;
  logic [7:0] sys_mode_reg_q;
  logic [7:0] sync_shape_q;
  logic sys_reserved;

  assign sys_reserved = reg_wdata[`B_RESERVED_HI] & reg_wdata[`B_RESERVED_HI-1];

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lf_source_q <= `RST_REG;
      dig_standard_q <= `RST_REG;
      dig_select_q <= `RST_REG;
      out_one_two_q <= `RST_REG;
      out_three_four_q <= `RST_REG;
      out_five_six_q <= `RST_REG;
      out_seven_en_q <= `RST_REG;
      aux_mode_reg_q <= `RST_REG;
      sys_mode_reg_q <= `RST_REG;
      sync_shape_q <= `RST_REG;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `OFS_LF_SOURCE)
        lf_source_q <= reg_wdata;
      else if (reg_addr == `OFS_DIG_STANDARD)
        dig_standard_q <= reg_wdata;
      else if (reg_addr == `OFS_DIG_SELECT)
        dig_select_q <= reg_wdata;
      else if (reg_addr == `OFS_OUT_ONE_TWO)
        out_one_two_q <= reg_wdata;
      else if (reg_addr == `OFS_OUT_THREE_FOUR)
        out_three_four_q <= reg_wdata;
      else if (reg_addr == `OFS_OUT_FIVE_SIX)
        out_five_six_q <= reg_wdata;
      else if (reg_addr == `OFS_OUT_SEVEN_EN)
        out_seven_en_q <= reg_wdata;
      else if (reg_addr == `OFS_AUX_MODE)
        aux_mode_reg_q <= reg_wdata;
      else if (reg_addr == `OFS_SYS_MODE)
      begin
        // Reserved system modes leave the mode field unchanged
        sys_mode_reg_q[`F_MODE_UPPER] <= reg_wdata[`F_MODE_UPPER];
        if (!sys_reserved)
          sys_mode_reg_q[`F_MODE] <= reg_wdata[`F_MODE];
      end
      else if (reg_addr == `OFS_SYNC_SHAPE)
        sync_shape_q <= reg_wdata;
    end
  end

  // ========================================================================
  // Register read port, unmapped offsets read zero
  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rdata_q <= `RST_REG;
    else if (reg_rd)
    begin
      if (reg_addr == `OFS_LF_SOURCE)
        reg_rdata_q <= lf_source_q;
      else if (reg_addr == `OFS_DIG_STANDARD)
        reg_rdata_q <= dig_standard_q;
      else if (reg_addr == `OFS_DIG_SELECT)
        reg_rdata_q <= dig_select_q;
      else if (reg_addr == `OFS_OUT_ONE_TWO)
        reg_rdata_q <= out_one_two_q;
      else if (reg_addr == `OFS_OUT_THREE_FOUR)
        reg_rdata_q <= out_three_four_q;
      else if (reg_addr == `OFS_OUT_FIVE_SIX)
        reg_rdata_q <= out_five_six_q;
      else if (reg_addr == `OFS_OUT_SEVEN_EN)
        reg_rdata_q <= out_seven_en_q;
      else if (reg_addr == `OFS_AUX_MODE)
        reg_rdata_q <= aux_mode_reg_q;
      else if (reg_addr == `OFS_SYS_MODE)
        reg_rdata_q <= sys_mode_reg_q;
      else if (reg_addr == `OFS_SYNC_SHAPE)
        reg_rdata_q <= sync_shape_q;
      else
        reg_rdata_q <= `RST_REG;
    end
  end

  // ========================================================================
  // Path mode and digital frequency controls to the synthesis paths
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sys_mode_q <= `RST_FIELD3;
      aux_mode_q <= `RST_FIELD4;
      aux_feedback_digital_q <= `RST_BIT;
      digital_freq_one_code_q <= `RST_FIELD3;
      digital_freq_two_code_q <= `RST_FIELD3;
    end
    else
    begin
      sys_mode_q <= sys_mode_reg_q[`F_MODE];
      if (sys_mode_reg_q[`B_AUX_FROM_SYS_EN])
        aux_mode_q <= {`AUX_FROM_SYS_CODE, sys_mode_reg_q[`F_AUX_FROM_SYS_SEL]};
      else
        aux_mode_q <= {1'b0, aux_mode_reg_q[`F_MODE]};
      aux_feedback_digital_q <= lf_source_q[`B_AUX_FB_DIGITAL];
      // Synthesizer input is the fixed 77.76 MHz clock, no APLL in the way
      digital_freq_one_code_q <= {dig_standard_q[`B_DIG_ONE_STD],
                                  dig_select_q[`F_DIG_ONE_SEL]};
      digital_freq_two_code_q <= {dig_standard_q[`B_DIG_TWO_STD],
                                  dig_select_q[`F_DIG_TWO_SEL]};
    end
  end

  // ========================================================================
  // Per-output source decode
  function automatic logic pick_source(
    input logic [3:0] code,
    input logic [2:0] idx,
    input logic [7:0] st,
    input logic [5:0] at,
    input logic lf8,
    input logic lf2,
    input logic d1,
    input logic d2
  );
    logic r;
    r = 1'b0;
    case (out_sel_t'(code))
      SEL_OFF: r = 1'b0;
      SEL_2K: r = lf2;
      SEL_8K: r = lf8;
      SEL_DIG_TWO: r = (idx == `IDX_OUT_SIX) ? st[`ST_DIV2] : d2;
      SEL_DIG_ONE: r = (idx == `IDX_OUT_SEVEN) ? st[`ST_DIV2] : d1;
      SEL_SYS_48: r = (idx == `IDX_OUT_SIX) ? st[`ST_DIV1] : st[`ST_DIV48];
      SEL_SYS_16: r = st[`ST_DIV16];
      SEL_SYS_12: r = st[`ST_DIV12];
      SEL_SYS_8: r = st[`ST_DIV8];
      SEL_SYS_6: r = st[`ST_DIV6];
      SEL_SYS_4: r = st[`ST_DIV4];
      SEL_AUX_64: r = (idx == `IDX_OUT_FOUR || idx == `IDX_OUT_FIVE) ?
                      at[`AT_DIV2] : at[`AT_DIV64];
      SEL_AUX_48: r = at[`AT_DIV48];
      SEL_AUX_16: r = at[`AT_DIV16];
      SEL_AUX_8: r = at[`AT_DIV8];
      SEL_AUX_4: r = at[`AT_DIV4];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ========================================================================
  // Sync shaping: 50:50 clock or pulse one output-three cycle wide
  logic [3:0] base_lvl;
  logic [3:0] base_prev_q;
  logic [3:0] armed_q;
  logic [3:0] pulse_q;
  logic [3:0] shaped;
  logic [1:0] shape_code [4];
  logic lf_8k;
  logic lf_2k;
  logic out3_prev_q;
  logic out3_rise;

  assign lf_8k = sync_shape_q[`B_LF_FROM_AUX] ? aux_8k : sys_8k;
  assign lf_2k = sync_shape_q[`B_LF_FROM_AUX] ? aux_2k : sys_2k;
  assign base_lvl = {lf_2k, lf_8k, sys_2k, sys_8k};
  assign shape_code[`SH_SYS_8K] = sync_shape_q[`F_SHAPE_8K];
  assign shape_code[`SH_SYS_2K] = sync_shape_q[`F_SHAPE_2K];
  assign shape_code[`SH_LF_8K] = sync_shape_q[`F_SHAPE_8K];
  assign shape_code[`SH_LF_2K] = sync_shape_q[`F_SHAPE_2K];
  assign out3_rise = clk_out_q[`IDX_OUT_THREE] & ~out3_prev_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      // Start from present levels so leaving reset makes no false edge
      base_prev_q <= base_lvl;
      armed_q <= `RST_FIELD4;
      pulse_q <= `RST_FIELD4;
      out3_prev_q <= `RST_BIT;
    end
    else
    begin
      out3_prev_q <= clk_out_q[`IDX_OUT_THREE];
      base_prev_q <= base_lvl;
      for (int i = 0; i < 4; i++)
      begin
        if (base_lvl[i] & ~base_prev_q[i])
          armed_q[i] <= 1'b1;
        else if (armed_q[i] & out3_rise)
          armed_q[i] <= 1'b0;
        if (armed_q[i] & out3_rise)
          pulse_q[i] <= 1'b1;
        else if (pulse_q[i] & out3_rise)
          pulse_q[i] <= 1'b0;
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      case (shape_t'(shape_code[i]))
        SHAPE_CLOCK: shaped[i] = base_lvl[i];
        SHAPE_PULSE: shaped[i] = pulse_q[i];
        SHAPE_CLOCK_INV: shaped[i] = ~base_lvl[i];
        SHAPE_PULSE_INV: shaped[i] = ~pulse_q[i];
        default: shaped[i] = 1'b0;
      endcase
    end
  end

  // ========================================================================
  // Configurable outputs one to seven
  logic [3:0] out_code [NUM_OUTS];

  assign out_code[0] = out_one_two_q[`F_LO_NIB];
  assign out_code[1] = out_one_two_q[`F_HI_NIB];
  assign out_code[2] = out_three_four_q[`F_LO_NIB];
  assign out_code[3] = out_three_four_q[`F_HI_NIB];
  assign out_code[4] = out_five_six_q[`F_LO_NIB];
  assign out_code[5] = out_five_six_q[`F_HI_NIB];
  assign out_code[6] = out_seven_en_q[`F_LO_NIB];

  always_ff @(posedge clk)
  begin
    if (reset)
      clk_out_q <= '0;
    else
    begin
      for (int i = 0; i < NUM_OUTS; i++)
        clk_out_q[i] <= pick_source(out_code[i], 3'(i), sys_taps, aux_taps,
                                    shaped[`SH_LF_8K], shaped[`SH_LF_2K],
                                    digital_freq_one, digital_freq_two);
    end
  end

  // ========================================================================
  // Composite, line-rate and sync outputs
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      composite_clock_out_q <= `RST_BIT;
      line_rate_out_q <= `RST_BIT;
      frame_sync_out_q <= `RST_BIT;
      multiframe_sync_out_q <= `RST_BIT;
    end
    else
    begin
      composite_clock_out_q <= out_seven_en_q[`B_CC_ENABLE] &
        (lf_source_q[`B_CC_LINE_SOURCE] ? aux_composite : sys_composite);
      line_rate_out_q <= out_seven_en_q[`B_LINE_ENABLE] &
        (lf_source_q[`B_CC_LINE_SOURCE] ? aux_line_rate : sys_line_rate);
      frame_sync_out_q <= ~out_seven_en_q[`B_FS_DISABLE] &
        shaped[`SH_SYS_8K];
      multiframe_sync_out_q <= ~out_seven_en_q[`B_MFS_DISABLE] &
        shaped[`SH_SYS_2K];
    end
  end

endmodule // output_clock_select

/* sim/output_clock_select_asserts.sv */
/*
  Checker for register port and output gating of output_clock_select.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module output_clock_select_asserts
  import output_clock_pkg::*;
#(
  parameter int NUM_OUTS = 7
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic [7:0] sys_taps,
  input wire logic [2:0] sys_mode_q,
  input wire logic [NUM_OUTS-1:0] clk_out_q,
  input wire logic composite_clock_out_q,
  input wire logic line_rate_out_q,
  input wire logic frame_sync_out_q,
  input wire logic multiframe_sync_out_q
);
  // ==========================================
  // Shadow copies of written selects
  logic [7:0] sh60_q;
  logic [7:0] sh63_q;
  always_ff @(posedge clk)
  begin
    if (reset)
      sh60_q <= 8'h00;
    else if (reg_wr && reg_addr == 8'h60)
      sh60_q <= reg_wdata;
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      sh63_q <= 8'h00;
    else if (reg_wr && reg_addr == 8'h63)
      sh63_q <= reg_wdata;
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  chk_unmapped_zero: assert property (
    reg_rd && !(reg_addr inside {8'h35, 8'h38, 8'h39, [8'h60:8'h65], 8'h7A})
    |=> reg_rdata_q == 8'h00) else $error("unmapped read not zero");
  chk_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata_q)) else $error("read data moved");
  chk_out_one_div4: assert property (
    !$past(reset) && $past(sh60_q[3:0]) == 4'hA |-> clk_out_q[0] == $past(sys_taps[2]))
    else $error("output one not system divide by four");
  chk_out_two_off: assert property (
    !$past(reset) && $past(sh60_q[7:4]) == 4'h0 |-> !clk_out_q[1])
    else $error("output two not off");
  chk_cc_gated: assert property (
    !$past(reset) && !$past(sh63_q[4]) |-> !composite_clock_out_q)
    else $error("composite output not gated");
  chk_line_gated: assert property (
    !$past(reset) && !$past(sh63_q[5]) |-> !line_rate_out_q)
    else $error("line rate output not gated");
  chk_fs_disabled: assert property (
    !$past(reset) && $past(sh63_q[6]) |-> !frame_sync_out_q)
    else $error("frame sync not disabled");
  chk_mfs_disabled: assert property (
    !$past(reset) && $past(sh63_q[7]) |-> !multiframe_sync_out_q)
    else $error("multiframe sync not disabled");
  chk_sys_mode_legal: assert property (
    sys_mode_q <= 3'h5) else $error("reserved system mode taken");
  chk_rsv_mode_kept: assert property (
    reg_wr && reg_addr == 8'h65 && reg_wdata[2:1] == 2'b11 |-> ##2 $stable(sys_mode_q))
    else $error("system mode changed by reserved code");
endmodule // output_clock_select_asserts

bind output_clock_select output_clock_select_asserts #(.NUM_OUTS(NUM_OUTS)) chk_u (
  .clk(clk),
  .reset(reset),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q),
  .sys_taps(sys_taps),
  .sys_mode_q(sys_mode_q),
  .clk_out_q(clk_out_q),
  .composite_clock_out_q(composite_clock_out_q),
  .line_rate_out_q(line_rate_out_q),
  .frame_sync_out_q(frame_sync_out_q),
  .multiframe_sync_out_q(multiframe_sync_out_q)
);

/* sim/clock_source_model.sv */
/*
  Source model: divided APLL taps, low rate clocks, digital and
  composite source levels feeding the output select block.
  Assumes a free running clk; levels change just after rising edges.
*/
`timescale 1ns/1ps
module clock_source_model
(
  input wire logic clk,
  output logic [7:0] sys_taps,
  output logic [5:0] aux_taps,
  output logic sys_8k,
  output logic sys_2k,
  output logic aux_8k,
  output logic aux_2k,
  output logic digital_freq_one,
  output logic digital_freq_two,
  output logic sys_composite,
  output logic sys_line_rate,
  output logic aux_composite,
  output logic aux_line_rate
);
  logic [31:0] lfsr_q = 32'h1357_9BDF;
  logic [7:0] cnt_q = 8'h00;
  always @(posedge clk)
  begin
    lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    cnt_q <= cnt_q + 8'h01;
  end
  assign sys_taps = lfsr_q[7:0];
  assign aux_taps = lfsr_q[13:8];
  assign digital_freq_one = lfsr_q[14];
  assign digital_freq_two = lfsr_q[15];
  assign sys_composite = lfsr_q[16];
  assign sys_line_rate = lfsr_q[17];
  assign aux_composite = lfsr_q[18];
  assign aux_line_rate = lfsr_q[19];
  assign sys_8k = cnt_q[3];
  assign sys_2k = cnt_q[5];
  assign aux_8k = cnt_q[4];
  assign aux_2k = cnt_q[6];
endmodule // clock_source_model

/* sim/test_output_clock_select.sv */
/*
  Testbench for output_clock_select: register map, output routing,
  gating and sync shaping.
  Assumes clock_source_model supplies all source levels.
*/
`timescale 1ns/1ps
module test_output_clock_select
  import output_clock_pkg::*;
  ;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata_q, sys_taps;
  logic [5:0] aux_taps;
  logic sys_8k, sys_2k, aux_8k, aux_2k, digital_freq_one, digital_freq_two;
  logic sys_composite, sys_line_rate, aux_composite, aux_line_rate;
  logic [2:0] sys_mode_q, digital_freq_one_code_q, digital_freq_two_code_q;
  logic [3:0] aux_mode_q;
  logic aux_feedback_digital_q, composite_clock_out_q, line_rate_out_q;
  logic frame_sync_out_q, multiframe_sync_out_q;
  logic [6:0] clk_out_q;
  logic [7:0] cfg [0:255];
  logic [7:0] maps [10] = '{8'h35, 8'h38, 8'h39, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64,
    8'h65, 8'h7A};
  int num_errors = 0;
  int tests_run = 0;
  always #20 clk = ~clk;
  output_clock_select #(.NUM_OUTS(7)) dut_u (
    .clk(clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q),
    .sys_taps(sys_taps),
    .aux_taps(aux_taps),
    .sys_8k(sys_8k),
    .sys_2k(sys_2k),
    .aux_8k(aux_8k),
    .aux_2k(aux_2k),
    .digital_freq_one(digital_freq_one),
    .digital_freq_two(digital_freq_two),
    .sys_composite(sys_composite),
    .sys_line_rate(sys_line_rate),
    .aux_composite(aux_composite),
    .aux_line_rate(aux_line_rate),
    .sys_mode_q(sys_mode_q),
    .aux_mode_q(aux_mode_q),
    .aux_feedback_digital_q(aux_feedback_digital_q),
    .digital_freq_one_code_q(digital_freq_one_code_q),
    .digital_freq_two_code_q(digital_freq_two_code_q),
    .clk_out_q(clk_out_q),
    .composite_clock_out_q(composite_clock_out_q),
    .line_rate_out_q(line_rate_out_q),
    .frame_sync_out_q(frame_sync_out_q),
    .multiframe_sync_out_q(multiframe_sync_out_q)
  );
  clock_source_model src_u (
    .clk(clk),
    .sys_taps(sys_taps),
    .aux_taps(aux_taps),
    .sys_8k(sys_8k),
    .sys_2k(sys_2k),
    .aux_8k(aux_8k),
    .aux_2k(aux_2k),
    .digital_freq_one(digital_freq_one),
    .digital_freq_two(digital_freq_two),
    .sys_composite(sys_composite),
    .sys_line_rate(sys_line_rate),
    .aux_composite(aux_composite),
    .aux_line_rate(aux_line_rate)
  );
  // ==========================================
  // Checking and bus tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == 8'h65 && d[2:1] == 2'b11)
      cfg[a] = {d[7:3], cfg[a][2:0]};
    else if (a inside {maps})
      cfg[a] = d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_q, cfg[a]);
  endtask
  function automatic logic exp_out(input int i, input logic [3:0] c, input logic [7:0] st,
    input logic [5:0] at, input logic [3:0] lf, input logic [1:0] dg);
    logic a;
    a = cfg[8'h7A][7];
    case (c)
      4'h1: return (a ? lf[3] : lf[1]) ^ cfg[8'h7A][1];
      4'h2: return (a ? lf[2] : lf[0]) ^ cfg[8'h7A][3];
      4'h3: return (i == 5) ? st[1] : dg[1];
      4'h4: return (i == 6) ? st[1] : dg[0];
      4'h5: return (i == 5) ? st[0] : st[7];
      4'h6: return st[6];
      4'h7: return st[5];
      4'h8: return st[4];
      4'h9: return st[3];
      4'hA: return st[2];
      4'hB: return (i == 3 || i == 4) ? at[0] : at[5];
      4'hC: return at[4];
      4'hD: return at[3];
      4'hE: return at[2];
      4'hF: return at[1];
      default: return 1'b0;
    endcase
  endfunction
  task automatic run_check(input int n);
    logic [7:0] st;
    logic [5:0] at;
    logic [3:0] lf;
    logic [1:0] dg, cp, ln;
    logic [6:0] e;
    logic [7:0] k;
    repeat (n)
    begin
      @(posedge clk);
      st = sys_taps;
      at = aux_taps;
      lf = {aux_2k, aux_8k, sys_2k, sys_8k};
      dg = {digital_freq_two, digital_freq_one};
      cp = {aux_composite, sys_composite};
      ln = {aux_line_rate, sys_line_rate};
      #1;
      k = cfg[8'h35];
      for (int i = 0; i < 7; i++)
        e[i] = exp_out(i, (i % 2) ? cfg[8'h60 + i / 2][7:4] : cfg[8'h60 + i / 2][3:0],
          st, at, lf, dg);
      chk({1'b0, clk_out_q}, {1'b0, e});
      chk(composite_clock_out_q, cfg[8'h63][4] & cp[k[4]]);
      chk(line_rate_out_q, cfg[8'h63][5] & ln[k[4]]);
      chk(frame_sync_out_q, !cfg[8'h63][6] & (lf[0] ^ cfg[8'h7A][3]));
      chk(multiframe_sync_out_q, !cfg[8'h63][7] & (lf[1] ^ cfg[8'h7A][1]));
      chk(sys_mode_q, cfg[8'h65][2:0]);
      chk(aux_mode_q, cfg[8'h65][6] ? {2'b10, cfg[8'h65][5:4]} : {1'b0, cfg[8'h64][2:0]});
      chk(aux_feedback_digital_q, k[6]);
      chk(digital_freq_one_code_q, {cfg[8'h38][5], cfg[8'h39][5:4]});
      chk(digital_freq_two_code_q, {cfg[8'h38][6], cfg[8'h39][7:6]});
    end
  endtask
  task automatic pulse_check(input logic inv);
    int r8 = 0, r2 = 0, p8 = 0, p2 = 0, h8 = 0;
    logic l8, l2, f8, f2;
    repeat (8) @(posedge clk);
    l8 = sys_8k;
    l2 = sys_2k;
    f8 = frame_sync_out_q ^ inv;
    f2 = multiframe_sync_out_q ^ inv;
    repeat (256)
    begin
      @(posedge clk);
      r8 += int'(sys_8k & !l8);
      r2 += int'(sys_2k & !l2);
      p8 += int'((frame_sync_out_q ^ inv) & !f8);
      p2 += int'((multiframe_sync_out_q ^ inv) & !f2);
      h8 += int'(frame_sync_out_q ^ inv);
      l8 = sys_8k;
      l2 = sys_2k;
      f8 = frame_sync_out_q ^ inv;
      f2 = multiframe_sync_out_q ^ inv;
    end
    chk(p8 + 1 >= r8 && p8 <= r8 + 1 && r8 > 0, 8'h01);
    chk(p2 + 1 >= r2 && p2 <= r2 + 1 && r2 > 0, 8'h01);
    chk(h8 < 128, 8'h01);
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h87372D53));
    foreach (cfg[a]) cfg[a] = 8'h00;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    foreach (maps[k]) rd(maps[k]);
    wr(8'h36, 8'h5A);
    rd(8'h36);
    rd(8'hFF);
    run_check(4);
    repeat (24)
    begin
      foreach (maps[k]) wr(maps[k], $urandom & ((maps[k] == 8'h7A) ? 8'hFA : 8'hFF));
      run_check(6);
      foreach (maps[k]) rd(maps[k]);
    end
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h7A, {c[0], 7'h00});
      wr(8'h60, {2{c[3:0]}});
      wr(8'h61, {2{c[3:0]}});
      wr(8'h62, {2{c[3:0]}});
      wr(8'h63, {4'($urandom), c[3:0]});
      run_check(6);
    end
    wr(8'h65, 8'h03);
    wr(8'h65, 8'hF6);
    rd(8'h65);
    run_check(2);
    wr(8'h61, 8'h0A);
    wr(8'h63, 8'h00);
    for (int s = 1; s < 4; s += 2)
    begin
      wr(8'h7A, {4'h0, s[1:0], s[1:0]});
      pulse_check(s[1]);
    end
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    foreach (cfg[a]) cfg[a] = 8'h00;
    rd(8'h61);
    rd(8'h7A);
    run_check(2);
    wrap_up();
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
endmodule // test_output_clock_select
